// ===== logic/cbo_pkg.sv
// Package holding register map, field layout and constants of the clock/buzzer output divider
package cbo_pkg;

  // Register map (printed offsets are byte addresses)
  localparam logic [19:0] CBO_SELECT_ADDR   = 20'hfffa5;
  localparam logic [19:0] CBO_REDIRECT_ADDR = 20'hfffa6;
  localparam logic [19:0] CBO_STATUS_ADDR   = 20'hfffa7;

  // Field positions of the select register
  localparam int CBO_GATE_BIT = 7;
  localparam int CBO_SEL_LSB  = 0;
  localparam int CBO_SEL_W    = 3;

  // Reset values
  localparam logic [7:0] CBO_SELECT_RST   = 8'h00;
  localparam logic [1:0] CBO_REDIRECT_RST = 2'h0;

  // Prescaler counter width
  localparam int CBO_PRESCALE_W = 13;

  // Redirect codes
  localparam logic [1:0] CBO_PIN_DEFAULT = 2'h0;
  localparam logic [1:0] CBO_PIN_ALT_ONE = 2'h1;
  localparam logic [1:0] CBO_PIN_ALT_TWO = 2'h2;

  // Register read/write request
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  data;
    logic [7:0]  bit_mask;
    logic        wr;
    logic        rd;
  } cbo_req_t;

  // Pin drive group
  typedef struct packed {
    logic default_out_pin;
    logic alt_out_pin_one;
    logic alt_out_pin_two;
  } cbo_pins_t;

endpackage

// ===== logic/cbo_prescaler.sv
// Free-running binary prescaler with tap selection
`timescale 1ns/1ps
module cbo_prescaler
  import cbo_pkg::*;
#(
  parameter int WIDTH = CBO_PRESCALE_W
)
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [2:0] sel,
  output logic            tap,
  output logic            wrap
);

  logic [WIDTH-1:0] count;

  // Free-running counter clocked by the main clock
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  // Map selection code to a counter tap; code 0 is the undivided clock marker
  function automatic int tap_index(input logic [2:0] code);
    begin
      if (code < 3'h5)
        tap_index = int'(code) - 1;
      else
        tap_index = int'(code) + 5;
    end
  endfunction

  // Mask of the counter bits from bit 0 up to the selected tap
  function automatic logic [WIDTH-1:0] low_mask(input logic [2:0] code);
    logic [WIDTH-1:0] m;
    begin
      m = '0;
      for (int i = 0; i < WIDTH; i++)
        if (i <= tap_index(code))
          m[i] = 1'b1;
      low_mask = m;
    end
  endfunction

  // Selected square wave (bit n toggles every 2^n cycles: divide by 2^(n+1))
  // End of a full period of the selected wave: all lower bits and tap set
  always_comb
  begin
    tap  = 1'b0;
    wrap = 1'b1;
    if (sel != 3'h0)
    begin
      tap  = count[tap_index(sel)];
      wrap = &(count | ~low_mask(sel));
    end
  end

endmodule

// ===== logic/cbo_divider.sv
// Clock/buzzer output divider with select register, pin redirect and glitch-free gating
//
// Functional notes
// - Bit 7 of the select register gates the output; 0 disables and is the default.
// - Code in bits 2..0 selects divide by 2, 2, 4, 8, 16, 2^11, 2^12 or 2^13 (codes 0 and 1 both divide by 2).
// - Reset clears the select register to zero.
// - The select register accepts single-bit writes as well as full byte writes.
// - The redirect code routes the output to the default, first or second alternate pin.
// - Output starts or stops at the first period boundary after the gate changes, with no narrow pulse.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module cbo_divider
  import cbo_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  wmask,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic             default_out_pin,
  output logic             alt_out_pin_one,
  output logic             alt_out_pin_two,
  output logic             clk_out_active
);

  logic            clk_out_gate;
  logic [2:0]      divider_sel;
  logic [1:0]      pin_redirect_reg;
  logic            tap;
  logic            wrap;
  logic            run;
  logic            wave;
  logic            next_wave;
  logic [7:0]      select_view;
  logic [7:0]      next_select;
  cbo_pins_t       next_pins;

  // Register read image; bits 6..3 are constant zero
  assign select_view = {clk_out_gate, 4'h0, divider_sel};

  // Bit-masked merge lets one bit or all eight be written
  assign next_select = (select_view & ~wmask) | (wdata & wmask);

  // Select register: gate and divider code
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clk_out_gate <= CBO_SELECT_RST[CBO_GATE_BIT];
      divider_sel  <= CBO_SELECT_RST[CBO_SEL_W-1:0];
    end
    else if (wr && addr == CBO_SELECT_ADDR)
    begin
      clk_out_gate <= next_select[CBO_GATE_BIT];
      divider_sel  <= next_select[CBO_SEL_W-1:0];
    end
  end

  // Redirect register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pin_redirect_reg <= CBO_REDIRECT_RST;
    else if (wr && addr == CBO_REDIRECT_ADDR)
      pin_redirect_reg <= (pin_redirect_reg & ~wmask[1:0]) | (wdata[1:0] & wmask[1:0]);
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == CBO_SELECT_ADDR)
        rdata <= select_view;
      else if (addr == CBO_REDIRECT_ADDR)
        rdata <= {6'h00, pin_redirect_reg};
      else if (addr == CBO_STATUS_ADDR)
        rdata <= {7'h00, run};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // Prescaler with tap selection
  cbo_prescaler #(
    .WIDTH (CBO_PRESCALE_W)
  ) u_prescaler (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sel     (divider_sel),
    .tap     (tap),
    .wrap    (wrap)
  );

  // Run flag follows the gate only at a period boundary, as the tap falls from high to low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      run <= 1'b0;
    else if (wrap)
      run <= clk_out_gate;
  end

  // Output wave: undivided code toggles every cycle, others follow the tap
  always_comb
  begin
    if (!run)
      next_wave = 1'b0;
    else if (divider_sel == 3'h0)
      next_wave = ~wave;
    else
      next_wave = tap;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      wave <= 1'b0;
    else
      wave <= next_wave;
  end

  // Route the wave to the chosen pin
  always_comb
  begin
    next_pins = '0;
    if (pin_redirect_reg == CBO_PIN_ALT_ONE)
      next_pins.alt_out_pin_one = next_wave;
    else if (pin_redirect_reg == CBO_PIN_ALT_TWO)
      next_pins.alt_out_pin_two = next_wave;
    else
      next_pins.default_out_pin = next_wave;
  end

  // Registered pin outputs
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      default_out_pin <= 1'b0;
      alt_out_pin_one <= 1'b0;
      alt_out_pin_two <= 1'b0;
      clk_out_active  <= 1'b0;
    end
    else
    begin
      default_out_pin <= next_pins.default_out_pin;
      alt_out_pin_one <= next_pins.alt_out_pin_one;
      alt_out_pin_two <= next_pins.alt_out_pin_two;
      clk_out_active  <= run;
    end
  end

endmodule

// ===== bench/cbo_divider_asserts.sv
// Checker watching the ports of the clock output divider
`timescale 1ns/1ps
module cbo_divider_asserts
  import cbo_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [19:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  wmask,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        default_out_pin,
  input wire logic        alt_out_pin_one,
  input wire logic        alt_out_pin_two,
  input wire logic        clk_out_active
);
  logic [7:0] sel_q;
  wire        pin = default_out_pin | alt_out_pin_one | alt_out_pin_two;
  // Shadow of the select register, masked writes, bits 6..3 dropped
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sel_q <= 8'h00;
    else if (wr && addr == CBO_SELECT_ADDR)
      sel_q <= ((sel_q & ~wmask) | (wdata & wmask)) & 8'h87;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  rd_sel_a: assert property (rd && addr == CBO_SELECT_ADDR |=> rdata == $past(sel_q)) else $error("bad readback");
  rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  unmapped_a: assert property (rd && addr > CBO_STATUS_ADDR |=> rdata == 8'h00) else $error("unmapped read");
  one_pin_a: assert property ($onehot0({default_out_pin, alt_out_pin_one, alt_out_pin_two})) else $error("two pins");
  run_gate_a: assert property ($rose(clk_out_active) |-> sel_q[7]) else $error("ran without gate");
  stop_gate_a: assert property ($fell(clk_out_active) |-> !sel_q[7]) else $error("stopped with gate");
  quiet_pin_a: assert property (!clk_out_active && !$past(clk_out_active) |-> !pin) else $error("pin moves idle");
  div_two_a: assert property (clk_out_active && $past(clk_out_active, 3) && sel_q[7] && $past(sel_q[7], 2)
    && sel_q[2:1] == 2'h0 |-> pin != $past(pin)) else $error("no toggle");
  div_eight_a: assert property ($rose(pin) && sel_q[2:0] == 3'h3 |-> pin [*4] ##1 !pin) else $error("bad div8");
  div_sixteen_a: assert property ($rose(pin) && sel_q[2:0] == 3'h4 |-> pin [*8] ##1 !pin) else $error("bad div16");
  cover property ($rose(clk_out_active));
  cover property ($rose(alt_out_pin_two));
  cover property (rd && addr == CBO_SELECT_ADDR);
endmodule
bind cbo_divider cbo_divider_asserts cbo_divider_asserts_inst (
  .clock           (clock),
  .sys_rst         (sys_rst),
  .addr            (addr),
  .wdata           (wdata),
  .wmask           (wmask),
  .wr              (wr),
  .rd              (rd),
  .rdata           (rdata),
  .default_out_pin (default_out_pin),
  .alt_out_pin_one (alt_out_pin_one),
  .alt_out_pin_two (alt_out_pin_two),
  .clk_out_active  (clk_out_active)
);

// ===== bench/cbo_listener.sv
// Buzzer-side listener measuring the wave period on the output pins
`timescale 1ns/1ps
module cbo_listener
(
  input wire logic       clock,
  input wire logic [2:0] pins,
  output int             period,
  output logic [2:0]     last_pins
);
  int   cnt = 0;
  logic prev = 1'b0;
  // Cycles between rising edges of whichever pin runs
  always_ff @(posedge clock)
  begin
    prev <= |pins;
    cnt <= cnt + 1;
    if ((|pins) && !prev)
    begin
      period <= cnt + 1;
      cnt <= 0;
      last_pins <= pins;
    end
  end
endmodule

// ===== bench/cbo_divider_tb_top.sv
// Testbench programming the divider and checking the output wave
`timescale 1ns/1ps
module cbo_divider_tb_top import cbo_pkg::*;;
  logic        clock, sys_rst, wr, rd, default_out_pin, alt_out_pin_one, alt_out_pin_two, clk_out_active;
  logic [19:0] addr;
  logic [7:0]  wdata, wmask, rdata;
  logic [2:0]  last_pins;
  int          period, e, error_cnt = 0, checks_done = 0;
  cbo_divider cbo_divider_inst (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .addr            (addr),
    .wdata           (wdata),
    .wmask           (wmask),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .default_out_pin (default_out_pin),
    .alt_out_pin_one (alt_out_pin_one),
    .alt_out_pin_two (alt_out_pin_two),
    .clk_out_active  (clk_out_active)
  );
  // Listener sees the pins as released port outputs driving low when idle
  cbo_listener cbo_listener_inst (.clock(clock), .pins({default_out_pin, alt_out_pin_one, alt_out_pin_two}),
    .period(period), .last_pins(last_pins));
  // Compare and count
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One-cycle masked write
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
    addr <= a;
    wdata <= d;
    wmask <= m;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  // Read, data checked in the following cycle
  task automatic rd_reg(input logic [19:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Clock at 50 ns
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Main sequence
  initial
  begin
    {sys_rst, wr, rd, addr, wdata, wmask} = {3'h4, 36'h0};
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(CBO_SELECT_ADDR, 8'h00);
    rd_reg(20'hfffa8, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      e = (c < 5) ? c : c + 6;
      wr_reg(CBO_REDIRECT_ADDR, 8'(c % 3), 8'hff);
      wr_reg(CBO_SELECT_ADDR, 8'(8'h78 | c), 8'hff);
      rd_reg(CBO_SELECT_ADDR, 8'(c));
      rd_reg(CBO_REDIRECT_ADDR, 8'(c % 3));
      wr_reg(CBO_SELECT_ADDR, 8'h80, 8'h80);
      repeat ((3 << e) + 8) @(posedge clock);
      #1;
      cmp(16'(period), 16'(c ? 1 << e : 2));
      cmp(16'(last_pins), 16'(3'h4 >> (c % 3)));
      cmp(16'(clk_out_active), 16'h1);
      rd_reg(CBO_STATUS_ADDR, 8'h01);
      wr_reg(CBO_SELECT_ADDR, 8'h00, 8'h80);
      repeat ((1 << e) + 6) @(posedge clock);
      #1;
      cmp(16'(clk_out_active), 16'h0);
      cmp(16'({default_out_pin, alt_out_pin_one, alt_out_pin_two}), 16'h0);
    end
    wr_reg(CBO_SELECT_ADDR, 8'h01, 8'hff);
    wr_reg(CBO_SELECT_ADDR, 8'h80, 8'h80);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    cmp(16'({clk_out_active, default_out_pin, alt_out_pin_one, alt_out_pin_two}), 16'h0);
    rd_reg(CBO_SELECT_ADDR, 8'h00);
    rd_reg(CBO_REDIRECT_ADDR, 8'h00);
    test_done();
  end
endmodule
